// ==== rtl/cju_pkg.sv ====
// Package of constants and types for the compare and jump unit
package cju_pkg;
    // ------------------------------------------------------------
    // Word and character layout
    // ------------------------------------------------------------
    localparam int WORD_W = 48;
    localparam int ADDR_W = 15;
    localparam int CHAR_W = 6;
    localparam int CHARS = 8;
    localparam int SIGN_BIT = 47;
    localparam logic [WORD_W-1:0] WORD_ZERO = 48'h0000_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;

    // ------------------------------------------------------------
    // Operation codes on the command port
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        CJU_OP_NONE = 3'h0,
        CJU_OP_EQ_OPERAND = 3'h1,
        CJU_OP_EQ_MQ = 3'h2,
        CJU_OP_GE_ALPHA = 3'h3,
        CJU_OP_GE_MQ_NUM = 3'h4,
        CJU_OP_ZERO = 3'h5,
        CJU_OP_UNCOND = 3'h6,
        CJU_OP_SUB_MQ_STORE = 3'h7
    } cju_op_type;
endpackage : cju_pkg

// ==== rtl/cju_cmp_if.sv ====
// Interface carrying the comparator operands and outcomes
`timescale 1ns/1ns
interface cju_cmp_if;
    import cju_pkg::*;
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] opnd;
    logic equal;
    logic ge_alpha;
    logic ge_signed;
    logic acc_zero;
    modport ctrl (output acc, output opnd, input equal, input ge_alpha,
        input ge_signed, input acc_zero);
    modport cmp (input acc, input opnd, output equal, output ge_alpha,
        output ge_signed, output acc_zero);
endinterface : cju_cmp_if

// ==== rtl/cju_comparator.sv ====
// Single comparator between accumulator and operand register
`timescale 1ns/1ns
module cju_comparator
    import cju_pkg::*;
(
    cju_cmp_if.cmp bus
);
    // ------------------------------------------------------------
    // Character weights
    // ------------------------------------------------------------
    // Unsigned code value, zone bits on top
    function automatic logic [CHAR_W-1:0] char_weight(
        input logic [WORD_W-1:0] w, input int idx);
        char_weight = w[idx*CHAR_W +: CHAR_W];
    endfunction : char_weight

    // ------------------------------------------------------------
    // Comparisons
    // ------------------------------------------------------------
    // Leftmost differing character decides the alpha test
    always_comb
    begin
        logic decided;
        logic ge;
        decided = 1'b0;
        ge = 1'b1;
        for (int i = CHARS - 1; i >= 0; i--)
        begin
            if (!decided && char_weight(bus.acc, i) !=
                char_weight(bus.opnd, i))
            begin
                decided = 1'b1;
                ge = char_weight(bus.acc, i) > char_weight(bus.opnd, i);
            end
        end
        bus.ge_alpha = ge;
    end

    // Full width equality, sign included
    assign bus.equal = (bus.acc == bus.opnd);
    assign bus.ge_signed = ($signed(bus.acc) >= $signed(bus.opnd));
    assign bus.acc_zero = (bus.acc == WORD_ZERO);
endmodule : cju_comparator

// ==== rtl/cju_compare_jump_unit.sv ====
// Compare and conditional jump unit, top level
`timescale 1ns/1ns
module cju_compare_jump_unit
    import cju_pkg::*;
#(
    parameter int WORD_WIDTH = WORD_W
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire cju_op_type cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [ADDR_W-1:0] cur_pc,
    input wire logic load_acc,
    input wire logic load_opnd,
    input wire logic load_mq,
    input wire logic [WORD_W-1:0] load_data,
    output logic [WORD_W-1:0] acc,
    output logic [WORD_W-1:0] opnd,
    output logic [WORD_W-1:0] mq,
    output logic [ADDR_W-1:0] next_pc_out,
    output logic pc_valid,
    output logic jump_taken,
    output logic [ADDR_W-1:0] return_address_reg,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [WORD_W-1:0] mem_wdata,
    output logic busy
);
    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        CJU_IDLE,
        CJU_COMPARE
    } cju_state_type;

    cju_state_type state;
    cju_op_type pend_op;
    logic [ADDR_W-1:0] pend_addr;
    logic [ADDR_W-1:0] pend_seq;
    logic [ADDR_W-1:0] seq_addr;
    logic cond;
    logic [WORD_W-1:0] diff;

    cju_cmp_if cmp_bus();

    // ------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------
    // The only comparator sees accumulator and operand register
    assign cmp_bus.acc = acc;
    assign cmp_bus.opnd = opnd;

    cju_comparator u_cmp
    (
        .bus(cmp_bus)
    );

    // Next sequential address and difference
    assign seq_addr = ADDR_W'(cur_pc + ADDR_STEP);
    assign diff = WORD_W'(acc - mq);

    // Jump condition for the pending operation
    function automatic logic is_jump(input cju_op_type op);
        is_jump = (op != CJU_OP_NONE) && (op != CJU_OP_SUB_MQ_STORE);
    endfunction : is_jump

    always_comb
    begin
        case (pend_op)
            CJU_OP_EQ_OPERAND: cond = cmp_bus.equal;
            CJU_OP_EQ_MQ: cond = cmp_bus.equal;
            CJU_OP_GE_ALPHA: cond = cmp_bus.ge_alpha;
            CJU_OP_GE_MQ_NUM: cond = cmp_bus.ge_signed;
            CJU_OP_ZERO: cond = cmp_bus.acc_zero;
            CJU_OP_UNCOND: cond = 1'b1;
            default: cond = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Takes a command, then resolves the jump one cycle later
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= CJU_IDLE;
            pend_op <= CJU_OP_NONE;
            pend_addr <= ADDR_ZERO;
            pend_seq <= ADDR_ZERO;
            busy <= 1'b0;
        end
        else
        begin
            case (state)
                CJU_IDLE:
                begin
                    if (cmd_valid && is_jump(cmd_op))
                    begin
                        state <= CJU_COMPARE;
                        pend_op <= cmd_op;
                        pend_addr <= cmd_addr;
                        pend_seq <= seq_addr;
                        busy <= 1'b1;
                    end
                end
                CJU_COMPARE:
                begin
                    state <= CJU_IDLE;
                    pend_op <= CJU_OP_NONE;
                    busy <= 1'b0;
                end
                default:
                begin
                    state <= CJU_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Program flow outputs
    // ------------------------------------------------------------
    // Picks jump target or next sequential address
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            next_pc_out <= ADDR_ZERO;
            pc_valid <= 1'b0;
            jump_taken <= 1'b0;
            return_address_reg <= ADDR_ZERO;
        end
        else if (state == CJU_COMPARE)
        begin
            next_pc_out <= cond ? pend_addr : pend_seq;
            pc_valid <= 1'b1;
            jump_taken <= cond;
            return_address_reg <= pend_seq;
        end
        else
        begin
            pc_valid <= 1'b0;
            jump_taken <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Arithmetic registers
    // ------------------------------------------------------------
    // Accumulator: loads and subtract-store result
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            acc <= WORD_ZERO;
        else if (state == CJU_IDLE && cmd_valid &&
            cmd_op == CJU_OP_SUB_MQ_STORE)
            acc <= diff;
        else if (load_acc && state == CJU_IDLE)
            acc <= load_data;
    end

    // Operand register: loads, mq copy and subtract-store result
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            opnd <= WORD_ZERO;
        else if (state == CJU_IDLE && cmd_valid &&
            cmd_op == CJU_OP_SUB_MQ_STORE)
            opnd <= diff;
        else if (state == CJU_IDLE && cmd_valid &&
            (cmd_op == CJU_OP_EQ_MQ || cmd_op == CJU_OP_GE_MQ_NUM))
            opnd <= mq;
        else if (load_opnd && state == CJU_IDLE)
            opnd <= load_data;
    end

    // Multiplier-quotient register
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            mq <= WORD_ZERO;
        else if (load_mq && state == CJU_IDLE)
            mq <= load_data;
    end

    // Memory write for subtract-store
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mem_we <= 1'b0;
            mem_addr <= ADDR_ZERO;
            mem_wdata <= WORD_ZERO;
        end
        else if (state == CJU_IDLE && cmd_valid &&
            cmd_op == CJU_OP_SUB_MQ_STORE)
        begin
            mem_we <= 1'b1;
            mem_addr <= cmd_addr;
            mem_wdata <= diff;
        end
        else
            mem_we <= 1'b0;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Jump command accepted while idle
    sequence take_s;
        state == CJU_IDLE && cmd_valid && is_jump(cmd_op);
    endsequence

    // Accepted command that copies mq into the operand register
    sequence mq_take_s;
        state == CJU_IDLE && cmd_valid &&
            (cmd_op == CJU_OP_EQ_MQ || cmd_op == CJU_OP_GE_MQ_NUM);
    endsequence

    // Accepted jump followed by its compare cycle
    sequence resolve_s;
        take_s ##1 state == CJU_COMPARE;
    endsequence

    // Accepted subtract-store command
    sequence store_s;
        state == CJU_IDLE && cmd_valid && cmd_op == CJU_OP_SUB_MQ_STORE;
    endsequence

    // Branch decisions, one per jump kind
    eq_jump_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (state == CJU_COMPARE && pend_op == CJU_OP_EQ_OPERAND)
        |=> jump_taken == (acc == opnd))
        else $error("equality jump wrong");
    eq_mq_jump_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (state == CJU_COMPARE && pend_op == CJU_OP_EQ_MQ)
        |=> jump_taken == (acc == opnd))
        else $error("mq equality jump wrong");
    alpha_ge_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (state == CJU_COMPARE && pend_op == CJU_OP_GE_ALPHA)
        |=> jump_taken == ($past(acc) >= $past(opnd)))
        else $error("alpha test wrong");
    num_ge_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (state == CJU_COMPARE && pend_op == CJU_OP_GE_MQ_NUM)
        |=> jump_taken == ($signed($past(acc)) >= $signed($past(opnd))))
        else $error("numeric test wrong");
    zero_jump_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (state == CJU_COMPARE && pend_op == CJU_OP_ZERO)
        |=> jump_taken == ($past(acc) == WORD_ZERO))
        else $error("zero test wrong");
    uncond_jump_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (state == CJU_COMPARE && pend_op == CJU_OP_UNCOND) |=> jump_taken)
        else $error("unconditional jump not taken");

    // Comparator wiring and register transfers
    single_cmp_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        cmp_bus.acc == acc && cmp_bus.opnd == opnd)
        else $error("comparator inputs wrong");
    mq_copy_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        mq_take_s |=> opnd == $past(mq))
        else $error("mq not copied");
    sub_store_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        store_s |=> mem_we && mem_addr == $past(cmd_addr) && opnd == acc &&
        mem_wdata == acc && acc == WORD_W'($past(acc) - $past(mq)))
        else $error("subtract store wrong");

    // Next address and return address after every jump
    seq_next_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        resolve_s |=> pc_valid && (jump_taken ||
        next_pc_out == $past(pend_seq)))
        else $error("fall through wrong");
    target_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        take_s |=> ##1 (!jump_taken || next_pc_out == $past(pend_addr)))
        else $error("target wrong");
    ret_addr_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        take_s |-> ##2 return_address_reg == $past(seq_addr, 2))
        else $error("return address wrong");
    fall_ret_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (pc_valid && !jump_taken) |-> next_pc_out == return_address_reg)
        else $error("fall through differs from return address");
    taken_pulse_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        jump_taken |-> pc_valid)
        else $error("taken flag outside result pulse");
endmodule : cju_compare_jump_unit

// ==== test/cju_tb.sv ====
// Self-checking testbench for the compare and jump unit
`timescale 1ns/1ns
module tb;
    import cju_pkg::*;
    typedef struct packed
    {
        logic is_st;
        logic tk;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] ret;
        logic [ADDR_W-1:0] at;
        logic [WORD_W-1:0] val;
    } cju_note_type;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    cju_op_type cmd_op = CJU_OP_NONE;
    logic [ADDR_W-1:0] cmd_addr = ADDR_ZERO;
    logic [ADDR_W-1:0] cur_pc = ADDR_ZERO;
    logic load_acc = 1'b0;
    logic load_opnd = 1'b0;
    logic load_mq = 1'b0;
    logic [WORD_W-1:0] load_data = WORD_ZERO;
    logic [WORD_W-1:0] acc, opnd, mq, mem_wdata;
    logic [ADDR_W-1:0] next_pc_out, return_address_reg, mem_addr;
    logic pc_valid, jump_taken, mem_we, busy;
    logic [WORD_W-1:0] m_acc, m_opnd, m_mq, a, b;
    logic [WORD_W-1:0] rnd = 48'h0000_0000_0036;
    cju_note_type notes[$];
    cju_note_type note;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Design, clock and hang guard
    // ------------------------------------------------------------
    cju_compare_jump_unit dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cur_pc(cur_pc), .load_acc(load_acc), .load_opnd(load_opnd),
        .load_mq(load_mq), .load_data(load_data), .acc(acc), .opnd(opnd),
        .mq(mq), .next_pc_out(next_pc_out), .pc_valid(pc_valid),
        .jump_taken(jump_taken), .return_address_reg(return_address_reg),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .busy(busy));

    always #50 ref_clk = ~ref_clk;

    // Cut a hang short well past the expected run length
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [WORD_W-1:0] lfsr(input logic [WORD_W-1:0] s);
        return {s[46:0], s[47] ^ s[46] ^ s[20] ^ s[19]};
    endfunction : lfsr

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got,
                exp);
        end
    endtask : chk

    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // Load one register for one idle cycle; put drops the strobes
    task automatic ld(input logic [2:0] sel, input logic [WORD_W-1:0] d);
        {load_acc, load_opnd, load_mq} = sel;
        load_data = d;
        @(negedge ref_clk);
    endtask : ld

    task automatic put(input logic [WORD_W-1:0] x, y, z);
        ld(3'h4, x);
        ld(3'h2, y);
        ld(3'h1, z);
        {load_acc, load_opnd, load_mq} = 3'h0;
        {m_acc, m_opnd, m_mq} = {x, y, z};
    endtask : put

    // One jump; a second strobe while busy must be ignored
    task automatic jump(input cju_op_type op, input logic dup);
        cju_note_type n;
        logic tk;
        case (op)
            CJU_OP_EQ_OPERAND: tk = (m_acc == m_opnd);
            CJU_OP_EQ_MQ: tk = (m_acc == m_mq);
            CJU_OP_GE_ALPHA: tk = (m_acc >= m_opnd);
            CJU_OP_GE_MQ_NUM: tk = ($signed(m_acc) >= $signed(m_mq));
            CJU_OP_ZERO: tk = (m_acc == WORD_ZERO);
            default: tk = 1'b1;
        endcase
        if (op inside {CJU_OP_EQ_MQ, CJU_OP_GE_MQ_NUM})
            m_opnd = m_mq;
        n = '{1'b0, tk, tk ? rnd[23:9] : rnd[38:24] + ADDR_STEP,
            rnd[38:24] + ADDR_STEP, ADDR_ZERO, m_opnd};
        if (op != CJU_OP_NONE)
            notes.push_back(n);
        cmd_op = op;
        cmd_addr = rnd[23:9];
        cur_pc = rnd[38:24];
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        chk(busy, op != CJU_OP_NONE);
        cmd_valid = dup;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        @(negedge ref_clk);
    endtask : jump

    // Back-to-back subtract-store commands
    task automatic store(input int k);
        cju_note_type n;
        repeat (k)
        begin
            m_acc = m_acc - m_mq;
            m_opnd = m_acc;
            rnd = lfsr(rnd);
            n = '{1'b1, 1'b0, ADDR_ZERO, ADDR_ZERO, rnd[14:0], m_acc};
            notes.push_back(n);
            cmd_op = CJU_OP_SUB_MQ_STORE;
            cmd_addr = rnd[14:0];
            cmd_valid = 1'b1;
            @(negedge ref_clk);
        end
        cmd_valid = 1'b0;
        @(negedge ref_clk);
    endtask : store

    // ------------------------------------------------------------
    // Result watcher: each pulse takes the oldest note
    // ------------------------------------------------------------
    always @(negedge ref_clk)
    begin
        if (pc_valid === 1'b1 || mem_we === 1'b1)
        begin
            if (notes.size() == 0)
                chk({pc_valid, mem_we}, 64'h0);
            else
            begin
                note = notes.pop_front();
                chk({pc_valid, mem_we}, {~note.is_st, note.is_st});
                chk(opnd, note.val);
                chk(mq, m_mq);
                if (note.is_st)
                    chk({mem_addr, acc, mem_wdata}, {note.at, note.val,
                        note.val});
                else
                    chk({jump_taken, next_pc_out, return_address_reg},
                        {note.tk, note.pc, note.ret});
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk({pc_valid, jump_taken, mem_we, busy, next_pc_out}, 64'h0);
        chk({acc, return_address_reg}, 64'h0);
        chk({opnd, mem_addr}, 64'h0);
        chk(mq | mem_wdata, 64'h0);
        // Character strings: leftmost differing character decides
        put(48'h0420C41461C8, 48'h6C20C41461C8, WORD_ZERO);
        jump(CJU_OP_GE_ALPHA, 1'b0);
        put({6'h11, 6'h12, 6'h13, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05},
            {6'h11, 6'h12, 6'h13, 6'h01, 6'h02, 6'h03, 6'h04, 6'h04},
            WORD_ZERO);
        jump(CJU_OP_GE_ALPHA, 1'b1);
        put({6'h30, 42'h0}, {6'h2F, 42'h3FF_FFFF_FFFF}, WORD_ZERO);
        jump(CJU_OP_GE_ALPHA, 1'b0);
        // Sign handling and full-width equality
        put(48'hFFFF_FFFF_FFFF, WORD_ZERO, 48'h0000_0000_0001);
        jump(CJU_OP_GE_MQ_NUM, 1'b0);
        put(48'h8000_0000_0005, WORD_ZERO, 48'h0000_0000_0005);
        jump(CJU_OP_EQ_MQ, 1'b0);
        store(3);
        jump(CJU_OP_GE_MQ_NUM, 1'b0);
        // Random operands and operations
        repeat (200)
        begin
            rnd = lfsr(rnd);
            a = rnd;
            rnd = lfsr(rnd);
            b = rnd;
            case (rnd[2:0])
                3'h0: a = WORD_ZERO;
                3'h1: b = a;
                3'h2: b = a ^ 48'h0000_0000_0001;
                default: b = b;
            endcase
            put(a, rnd[4] ? a : b, rnd[5] ? a : b);
            if (cju_op_type'(rnd[8:6]) == CJU_OP_SUB_MQ_STORE)
                store(int'(rnd[10:9]) + 1);
            else
                jump(cju_op_type'(rnd[8:6]), rnd[11]);
        end
        repeat (4) @(negedge ref_clk);
        chk(notes.size(), 64'h0);
        end_sim();
    end
endmodule : tb
